// File: core/cmplc_pkg.sv
/*
 package of the comparator output and latch control block:
 register offsets, field positions, reset values, bus and ladder carriers.
 assumes an 8-bit register port with a 3-bit word address.
*/
package cmplc_pkg;

   // ==================================================
   // register offsets
   localparam logic [2:0] CMPLC_ADDR_CMP1_CTRL = 3'h0;
   localparam logic [2:0] CMPLC_ADDR_CMP2_CTRL = 3'h1;
   localparam logic [2:0] CMPLC_ADDR_AUX_CTRL = 3'h2;
   localparam logic [2:0] CMPLC_ADDR_LATCH_CTRL = 3'h3;
   localparam logic [2:0] CMPLC_ADDR_LADDER_CTRL = 3'h4;
   localparam logic [2:0] CMPLC_ADDR_STATUS = 3'h5;

   // ==================================================
   // per-comparator control fields
   localparam int CMPLC_PC_RESULT = 6;
   localparam int CMPLC_PC_OE = 5;

   // ==================================================
   // comparator_two_aux_control fields
   localparam int CMPLC_AUX_MIRROR_ONE = 7;
   localparam int CMPLC_AUX_MIRROR_TWO = 6;
   localparam int CMPLC_AUX_REF_ONE = 5;
   localparam int CMPLC_AUX_REF_TWO = 4;
   localparam int CMPLC_AUX_GATE_SEL = 1;
   localparam int CMPLC_AUX_SYNC = 0;
   localparam logic [7:0] CMPLC_AUX_RESET = 8'h02;

   // ==================================================
   // set_reset_latch_control fields
   localparam int CMPLC_LC_CFG_TWO = 7;
   localparam int CMPLC_LC_CFG_ONE = 6;
   localparam int CMPLC_LC_SET_EN = 5;
   localparam int CMPLC_LC_RESET_EN = 4;
   localparam int CMPLC_LC_SET_PULSE = 3;
   localparam int CMPLC_LC_RESET_PULSE = 2;
   localparam int CMPLC_LC_FIXED_EN = 0;
   localparam logic [7:0] CMPLC_LATCH_RESET = 8'h00;

   // ==================================================
   // ladder_reference_control fields
   localparam int CMPLC_LR_ENABLE = 7;
   localparam int CMPLC_LR_PIN_OUT = 6;
   localparam int CMPLC_LR_RANGE = 5;
   localparam int CMPLC_LR_SOURCE = 4;
   localparam int CMPLC_LR_LEVEL_LSB = 0;
   localparam int CMPLC_LR_LEVEL_W = 4;
   localparam logic [7:0] CMPLC_LADDER_RESET = 8'h00;
   localparam logic [3:0] CMPLC_LEVEL_ZERO = 4'h0;

   // ==================================================
   // synchroniser lanes
   localparam int CMPLC_SYNC_W = 5;
   localparam int CMPLC_S_CMP1 = 0;
   localparam int CMPLC_S_CMP2 = 1;
   localparam int CMPLC_S_TCLK = 2;
   localparam int CMPLC_S_GATE = 3;
   localparam int CMPLC_S_OSC = 4;

   // ==================================================
   // carriers
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cmplc_bus_req_t;

   typedef struct packed {
      logic power;
      logic pin_out;
      logic range_low;
      logic source_ext;
      logic [3:0] level;
      logic clamp_gnd;
   } cmplc_ladder_t;

endpackage

// File: core/cmplc_core.sv
/*
 comparator output and latch control: timer gate source and sync,
 mirror readout, reference selects, set/reset latch with pin muxes,
 ladder and fixed reference controls, change-detect latches.
 assumes comparator results, timer clock, external gate and oscillator
 status arrive asynchronously; pin direction bits come from port logic on CLK.
*/
// Implementation choices: the strobed register port and the register offsets.
//
// Contract
// - gate select clear: timer counts by comparator two when running and gated.
// - gate select set: gate comes from external pin; bit resets to one.
// - sync bit set: comparator two captured on timer clock falling edge.
// - capture uses the prescaled timer clock, not the raw source.
// - timer advances on rising edge, capture on falling edge.
// - sync bit clear: comparator two passes through uncaptured.
// - aux register bits 7 and 6 return both results in one read.
// - mirror reads leave change-detect latches untouched.
// - reference bit 5 picks ladder or fixed reference for comparator one.
// - reference bit 4 picks ladder or fixed reference for comparator two.
// - latch set by comparator one or pulse, reset by comparator two or pulse.
// - comparators act on latch only while their enable bits are one.
// - set and reset together leave latch reset.
// - writing one to pulse bits fires pulse, bit clears at once.
// - bit 7 puts inverted latch on pin two, bit 6 true latch on pin one.
// - after reset both pins carry plain comparator results.
// - pin driven only when output enable set and direction is output.
// - result bits show true comparator result regardless of latch.
// - ladder has two ranges of 16 levels, powered only when enabled.
// - ladder off, low range, level zero: output tied to ground.
// - fixed reference on by its bit or while fast oscillator runs.
// - reading a comparator control register captures its result.
`timescale 1ns/1ps
module cmplc_core (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port
   input wire cmplc_pkg::cmplc_bus_req_t BUS,
   output logic [7:0] RDATA,
   // analog and timer side, asynchronous
   input wire logic CMP1_RESULT,
   input wire logic CMP2_RESULT,
   input wire logic TMR_CLK_PRESCALED,
   input wire logic EXT_GATE_PIN,
   input wire logic FAST_OSC_RUNNING,
   // timer control, same clock
   input wire logic TMR_ON,
   input wire logic TMR_GATE_EN,
   output logic TMR_GATE,
   output logic TMR_TICK,
   // port pins, same clock
   input wire logic [1:0] PIN_DIR,
   output logic CMP1_PIN_O,
   output logic CMP1_PIN_OE,
   output logic CMP2_PIN_O,
   output logic CMP2_PIN_OE,
   // references
   output logic CMP1_REF_LADDER,
   output logic CMP2_REF_LADDER,
   output logic FIXED_REF_ON,
   output cmplc_pkg::cmplc_ladder_t LADDER,
   // change detection
   output logic CMP1_MISMATCH,
   output logic CMP2_MISMATCH
);
   import cmplc_pkg::*;

   // ==================================================
   // input synchronisers
   logic [CMPLC_SYNC_W-1:0] sync_meta;
   logic [CMPLC_SYNC_W-1:0] sync_q;
   logic [CMPLC_SYNC_W-1:0] async_in;
   logic tclk_d;
   logic tclk_fall;
   logic tclk_rise;
   logic cmp1;
   logic cmp2;

   assign async_in = {FAST_OSC_RUNNING, EXT_GATE_PIN, TMR_CLK_PRESCALED, CMP2_RESULT, CMP1_RESULT};

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         sync_meta <= '0;
         sync_q <= '0;
      end else begin
         sync_meta <= async_in;
         sync_q <= sync_meta;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         tclk_d <= 1'b0;
      end else begin
         tclk_d <= sync_q[CMPLC_S_TCLK];
      end
   end

   assign cmp1 = sync_q[CMPLC_S_CMP1];
   assign cmp2 = sync_q[CMPLC_S_CMP2];
   assign tclk_fall = tclk_d & ~sync_q[CMPLC_S_TCLK];
   assign tclk_rise = ~tclk_d & sync_q[CMPLC_S_TCLK];

   // ==================================================
   // registers
   logic cmp1_oe;
   logic cmp2_oe;
   logic [7:0] aux;
   logic [7:0] lctl;
   logic [7:0] lad;
   logic set_pulse;
   logic reset_pulse;
   logic wr_cmp1;
   logic wr_cmp2;
   logic wr_aux;
   logic wr_latch;
   logic wr_ladder;

   assign wr_cmp1 = BUS.wr && BUS.addr == CMPLC_ADDR_CMP1_CTRL;
   assign wr_cmp2 = BUS.wr && BUS.addr == CMPLC_ADDR_CMP2_CTRL;
   assign wr_aux = BUS.wr && BUS.addr == CMPLC_ADDR_AUX_CTRL;
   assign wr_latch = BUS.wr && BUS.addr == CMPLC_ADDR_LATCH_CTRL;
   assign wr_ladder = BUS.wr && BUS.addr == CMPLC_ADDR_LADDER_CTRL;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cmp1_oe <= 1'b0;
         cmp2_oe <= 1'b0;
      end else begin
         if (wr_cmp1) begin
            cmp1_oe <= BUS.wdata[CMPLC_PC_OE];
         end
         if (wr_cmp2) begin
            cmp2_oe <= BUS.wdata[CMPLC_PC_OE];
         end
      end
   end

   // only the writable aux bits are stored; mirrors are live
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         aux <= CMPLC_AUX_RESET;
      end else if (wr_aux) begin
         aux <= {2'b00, BUS.wdata[CMPLC_AUX_REF_ONE], BUS.wdata[CMPLC_AUX_REF_TWO], 2'b00,
                 BUS.wdata[CMPLC_AUX_GATE_SEL], BUS.wdata[CMPLC_AUX_SYNC]};
      end
   end

   // pulse bits are never stored, so they read back as zero
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         lctl <= CMPLC_LATCH_RESET;
      end else if (wr_latch) begin
         lctl <= {BUS.wdata[7:4], 3'b000, BUS.wdata[CMPLC_LC_FIXED_EN]};
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         set_pulse <= 1'b0;
         reset_pulse <= 1'b0;
      end else begin
         set_pulse <= wr_latch & BUS.wdata[CMPLC_LC_SET_PULSE];
         reset_pulse <= wr_latch & BUS.wdata[CMPLC_LC_RESET_PULSE];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         lad <= CMPLC_LADDER_RESET;
      end else if (wr_ladder) begin
         lad <= BUS.wdata;
      end
   end

   // ==================================================
   // timer gate and comparator two sync
   logic cmp2_held;
   logic cmp2_timer;
   logic next_gate;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         cmp2_held <= 1'b0;
      end else if (tclk_fall) begin
         cmp2_held <= cmp2;
      end
   end

   assign cmp2_timer = aux[CMPLC_AUX_SYNC] ? cmp2_held : cmp2;
   assign next_gate = aux[CMPLC_AUX_GATE_SEL] ? sync_q[CMPLC_S_GATE] : cmp2_timer;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         TMR_GATE <= 1'b0;
      end else begin
         TMR_GATE <= next_gate;
      end
   end

   assign TMR_TICK = tclk_rise & TMR_ON & (~TMR_GATE_EN | TMR_GATE);

   // ==================================================
   // set/reset latch and pin muxes
   logic q;
   logic latch_set;
   logic latch_reset;

   assign latch_set = (cmp1 & lctl[CMPLC_LC_SET_EN]) | set_pulse;
   assign latch_reset = (cmp2 & lctl[CMPLC_LC_RESET_EN]) | reset_pulse;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         q <= 1'b0;
      end else if (latch_reset) begin
         q <= 1'b0;
      end else if (latch_set) begin
         q <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         CMP1_PIN_O <= 1'b0;
         CMP2_PIN_O <= 1'b0;
         CMP1_PIN_OE <= 1'b0;
         CMP2_PIN_OE <= 1'b0;
      end else begin
         CMP1_PIN_O <= lctl[CMPLC_LC_CFG_ONE] ? q : cmp1;
         CMP2_PIN_O <= lctl[CMPLC_LC_CFG_TWO] ? ~q : cmp2;
         CMP1_PIN_OE <= cmp1_oe & ~PIN_DIR[0];
         CMP2_PIN_OE <= cmp2_oe & ~PIN_DIR[1];
      end
   end

   // ==================================================
   // references
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         CMP1_REF_LADDER <= 1'b0;
         CMP2_REF_LADDER <= 1'b0;
         FIXED_REF_ON <= 1'b0;
      end else begin
         CMP1_REF_LADDER <= aux[CMPLC_AUX_REF_ONE];
         CMP2_REF_LADDER <= aux[CMPLC_AUX_REF_TWO];
         FIXED_REF_ON <= lctl[CMPLC_LC_FIXED_EN] | sync_q[CMPLC_S_OSC];
      end
   end

   assign LADDER.power = lad[CMPLC_LR_ENABLE];
   assign LADDER.pin_out = lad[CMPLC_LR_PIN_OUT];
   assign LADDER.range_low = lad[CMPLC_LR_RANGE];
   assign LADDER.source_ext = lad[CMPLC_LR_SOURCE];
   assign LADDER.level = lad[CMPLC_LR_LEVEL_LSB +: CMPLC_LR_LEVEL_W];
   assign LADDER.clamp_gnd = ~lad[CMPLC_LR_ENABLE] & lad[CMPLC_LR_RANGE]
                             & (lad[CMPLC_LR_LEVEL_LSB +: CMPLC_LR_LEVEL_W] == CMPLC_LEVEL_ZERO);

   // ==================================================
   // change detection and read data
   logic seen1;
   logic seen2;
   logic acc_cmp1;
   logic acc_cmp2;
   logic [7:0] next_rdata;

   // a write counts as an access too, as it reads first
   assign acc_cmp1 = (BUS.rd | BUS.wr) && BUS.addr == CMPLC_ADDR_CMP1_CTRL;
   assign acc_cmp2 = (BUS.rd | BUS.wr) && BUS.addr == CMPLC_ADDR_CMP2_CTRL;

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         seen1 <= 1'b0;
         seen2 <= 1'b0;
      end else begin
         if (acc_cmp1) begin
            seen1 <= cmp1;
         end
         if (acc_cmp2) begin
            seen2 <= cmp2;
         end
      end
   end

   assign CMP1_MISMATCH = seen1 ^ cmp1;
   assign CMP2_MISMATCH = seen2 ^ cmp2;

   always_comb begin
      next_rdata = 8'h00;
      case (BUS.addr)
         CMPLC_ADDR_CMP1_CTRL: begin
            next_rdata[CMPLC_PC_RESULT] = cmp1;
            next_rdata[CMPLC_PC_OE] = cmp1_oe;
         end
         CMPLC_ADDR_CMP2_CTRL: begin
            next_rdata[CMPLC_PC_RESULT] = cmp2;
            next_rdata[CMPLC_PC_OE] = cmp2_oe;
         end
         CMPLC_ADDR_AUX_CTRL: begin
            next_rdata = aux;
            next_rdata[CMPLC_AUX_MIRROR_ONE] = cmp1;
            next_rdata[CMPLC_AUX_MIRROR_TWO] = cmp2;
         end
         CMPLC_ADDR_LATCH_CTRL: next_rdata = lctl;
         CMPLC_ADDR_LADDER_CTRL: next_rdata = lad;
         CMPLC_ADDR_STATUS: next_rdata = {5'h00, CMP2_MISMATCH, CMP1_MISMATCH, q};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= BUS.rd ? next_rdata : 8'h00;
      end
   end

   // ==================================================
   // assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   property p_gate_cmp;
      !aux[CMPLC_AUX_GATE_SEL] |=> TMR_GATE == $past(cmp2_timer);
   endproperty
   a_gate_cmp: assert property (p_gate_cmp) else $error("gate not from comparator two");

   property p_gate_ext;
      aux[CMPLC_AUX_GATE_SEL] |=> TMR_GATE == $past(sync_q[CMPLC_S_GATE]);
   endproperty
   a_gate_ext: assert property (p_gate_ext) else $error("gate not from external pin");

   property p_sync_capture;
      tclk_fall |=> cmp2_held == $past(cmp2) ##1 (tclk_fall || $stable(cmp2_held));
   endproperty
   a_sync_capture: assert property (p_sync_capture) else $error("comparator two not captured on fall");

   property p_no_race;
      TMR_TICK |-> !tclk_fall && $stable(cmp2_held);
   endproperty
   a_no_race: assert property (p_no_race) else $error("tick and capture coincide");

   property p_async_pass;
      !aux[CMPLC_AUX_SYNC] |-> cmp2_timer == sync_q[CMPLC_S_CMP2];
   endproperty
   a_async_pass: assert property (p_async_pass) else $error("unsynced path not transparent");

   property p_mirror;
      BUS.rd && BUS.addr == CMPLC_ADDR_AUX_CTRL |=> RDATA[7:6] == $past({cmp1, cmp2});
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror bits wrong");

   property p_mirror_quiet;
      BUS.rd && !BUS.wr && BUS.addr == CMPLC_ADDR_AUX_CTRL |=> $stable(seen1) && $stable(seen2);
   endproperty
   a_mirror_quiet: assert property (p_mirror_quiet) else $error("mirror read moved change latch");

   property p_reset_dominant;
      latch_set && latch_reset |=> !q;
   endproperty
   a_reset_dominant: assert property (p_reset_dominant) else $error("latch not reset dominant");

   property p_pulse_once;
      wr_latch && BUS.wdata[CMPLC_LC_SET_PULSE] |=> set_pulse ##1 (q || $past(latch_reset));
   endproperty
   a_pulse_once: assert property (p_pulse_once) else $error("set pulse did not set latch");

   property p_pulse_short;
      set_pulse && !(wr_latch && BUS.wdata[CMPLC_LC_SET_PULSE]) |=> !set_pulse;
   endproperty
   a_pulse_short: assert property (p_pulse_short) else $error("set pulse longer than one cycle");

   property p_pin_two;
      lctl[CMPLC_LC_CFG_TWO] |=> CMP2_PIN_O == !$past(q);
   endproperty
   a_pin_two: assert property (p_pin_two) else $error("pin two not inverted latch");

   property p_pin_enable;
      CMP1_PIN_OE |-> $past(cmp1_oe) && !$past(PIN_DIR[0]);
   endproperty
   a_pin_enable: assert property (p_pin_enable) else $error("pin one driven while disabled");

   property p_fixed_ref;
      sync_q[CMPLC_S_OSC] |=> FIXED_REF_ON;
   endproperty
   a_fixed_ref: assert property (p_fixed_ref) else $error("fixed reference off with fast oscillator");

   property p_clamp;
      LADDER.clamp_gnd |-> !LADDER.power && LADDER.range_low && LADDER.level == CMPLC_LEVEL_ZERO;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp under wrong settings");

   c_soft_set: cover property (set_pulse ##1 q);
   c_cmp_reset: cover property (q ##1 (cmp2 && lctl[CMPLC_LC_RESET_EN]) ##1 !q);
   c_gated_tick: cover property (!aux[CMPLC_AUX_GATE_SEL] && aux[CMPLC_AUX_SYNC] && TMR_TICK);
   c_mismatch: cover property (CMP1_MISMATCH ##1 acc_cmp1 ##1 !CMP1_MISMATCH);

endmodule

// File: tb/cmplc_far_model.sv
/*
 far-side model: comparator results, prescaled timer clock, gate pin,
 oscillator status and port direction bits.
 assumes the bench commands every level; timer clock runs only on request.
*/
`timescale 1ns/1ps
module cmplc_far_model (
   // commands from bench
   input wire logic cmp1_lvl,
   input wire logic cmp2_lvl,
   input wire logic tclk_run,
   input wire logic gate_lvl,
   input wire logic osc_lvl,
   input wire logic [1:0] dir,
   // toward the block
   output logic cmp1,
   output logic cmp2,
   output logic tclk,
   output logic gate,
   output logic osc,
   output logic [1:0] pin_dir
);
   // ==========================
   // analog results and port side
   assign cmp1 = cmp1_lvl;
   assign cmp2 = cmp2_lvl;
   assign gate = gate_lvl;
   assign osc = osc_lvl;
   assign pin_dir = dir;

   // ==========================
   // prescaled timer clock, unrelated in phase, parks low when stopped
   initial begin
      tclk = 1'b0;
      forever begin
         #37;
         tclk = tclk_run ? ~tclk : 1'b0;
      end
   end
endmodule

// File: tb/comparator_output_latch_ctrl_tb.sv
/*
 self-checking bench of the comparator output and latch control block.
 assumes the far-side model and the register port timing of the block.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("ERROR %0t got %h expected %h", $time, got, exp); end end
module comparator_output_latch_ctrl_tb;
   import cmplc_pkg::*;
   logic clk, rst_b, tmr_on, tmr_gate_en, tmr_gate, tmr_tick;
   logic c1, c2, run, g, osc, p1, p1_oe, p2, p2_oe, ref1, ref2, fixed, mm1, mm2;
   logic m_c1, m_c2, m_tclk, m_gate, m_osc;
   logic [1:0] dir, m_dir;
   logic [7:0] rdata, d;
   cmplc_bus_req_t bus;
   cmplc_ladder_t ladder;
   int n_mismatch = 0;
   int comparisons = 0;
   int n;

   cmplc_far_model i_cmplc_far_model (.cmp1_lvl(c1), .cmp2_lvl(c2), .tclk_run(run), .gate_lvl(g),
      .osc_lvl(osc), .dir(dir), .cmp1(m_c1), .cmp2(m_c2), .tclk(m_tclk), .gate(m_gate), .osc(m_osc),
      .pin_dir(m_dir));
   cmplc_core i_cmplc_core (.CLK(clk), .RST_B(rst_b), .BUS(bus), .RDATA(rdata), .CMP1_RESULT(m_c1),
      .CMP2_RESULT(m_c2), .TMR_CLK_PRESCALED(m_tclk), .EXT_GATE_PIN(m_gate), .FAST_OSC_RUNNING(m_osc),
      .TMR_ON(tmr_on), .TMR_GATE_EN(tmr_gate_en), .TMR_GATE(tmr_gate), .TMR_TICK(tmr_tick),
      .PIN_DIR(m_dir), .CMP1_PIN_O(p1), .CMP1_PIN_OE(p1_oe), .CMP2_PIN_O(p2), .CMP2_PIN_OE(p2_oe),
      .CMP1_REF_LADDER(ref1), .CMP2_REF_LADDER(ref2), .FIXED_REF_ON(fixed), .LADDER(ladder),
      .CMP1_MISMATCH(mm1), .CMP2_MISMATCH(mm2));

   // ==========================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #400000;
      n_mismatch++;
      finish_test();
   end

   // ==========================
   // bus and timing helpers
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      rd(a);
      `CHK(d, e)
   endtask
   task automatic q_chk(input logic e);
      rd(CMPLC_ADDR_STATUS);
      `CHK(d[0], e)
   endtask
   task automatic ticks();
      n = 0;
      repeat (200) begin
         @(negedge clk);
         if (tmr_tick !== 1'b0) n++;
      end
   endtask

   // ==========================
   // scenarios
   task automatic t_reset();
      rchk(CMPLC_ADDR_AUX_CTRL, CMPLC_AUX_RESET);
      rchk(CMPLC_ADDR_LATCH_CTRL, 8'h00);
      rchk(3'h6, 8'h00);
      `CHK({p1, p1_oe, p2, p2_oe}, 4'h0)
   endtask
   task automatic t_mirror();
      c1 <= 1'b1;
      wt(5);
      rchk(CMPLC_ADDR_AUX_CTRL, 8'h82);
      `CHK(mm1, 1'b1)
      rchk(CMPLC_ADDR_CMP1_CTRL, 8'h40);
      `CHK(mm1, 1'b0)
      c2 <= 1'b1;
      wt(5);
      rchk(CMPLC_ADDR_AUX_CTRL, 8'hc2);
      `CHK(mm2, 1'b1)
      rchk(CMPLC_ADDR_CMP2_CTRL, 8'h40);
      `CHK(mm2, 1'b0)
      c1 <= 1'b0;
      c2 <= 1'b0;
      wt(5);
      rd(CMPLC_ADDR_CMP1_CTRL);
      rd(CMPLC_ADDR_CMP2_CTRL);
   endtask
   task automatic t_refsel();
      wr(CMPLC_ADDR_AUX_CTRL, 8'h22);
      wt(2);
      `CHK({ref1, ref2}, 2'b10)
      wr(CMPLC_ADDR_AUX_CTRL, 8'h12);
      wt(2);
      `CHK({ref1, ref2}, 2'b01)
      wr(CMPLC_ADDR_AUX_CTRL, 8'h02);
   endtask
   task automatic t_latch();
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h08);
      q_chk(1'b1);
      rchk(CMPLC_ADDR_LATCH_CTRL, 8'h00);
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h0c);
      q_chk(1'b0);
      c1 <= 1'b1;
      wt(5);
      q_chk(1'b0);
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h20);
      wt(2);
      q_chk(1'b1);
      c1 <= 1'b0;
      c2 <= 1'b1;
      wt(5);
      q_chk(1'b1);
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h10);
      wt(2);
      q_chk(1'b0);
      c1 <= 1'b1;
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h30);
      wt(5);
      q_chk(1'b0);
      c2 <= 1'b0;
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h00);
   endtask
   task automatic t_pins();
      wr(CMPLC_ADDR_CMP1_CTRL, 8'h20);
      wr(CMPLC_ADDR_CMP2_CTRL, 8'h20);
      dir <= 2'b11;
      wt(3);
      `CHK({p1_oe, p2_oe}, 2'b00)
      dir <= 2'b00;
      wt(3);
      `CHK({p1_oe, p2_oe, p1, p2}, 4'he)
      wr(CMPLC_ADDR_LATCH_CTRL, 8'hc4);
      wt(3);
      `CHK({p1, p2}, 2'b01)
      wr(CMPLC_ADDR_LATCH_CTRL, 8'hc8);
      wt(3);
      `CHK({p1, p2}, 2'b10)
      rchk(CMPLC_ADDR_CMP2_CTRL, 8'h20);
      wr(CMPLC_ADDR_CMP1_CTRL, 8'h00);
      wt(3);
      `CHK({p1_oe, p2_oe}, 2'b01)
      c1 <= 1'b0;
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h04);
   endtask
   task automatic t_timer();
      tmr_on <= 1'b1;
      tmr_gate_en <= 1'b1;
      wr(CMPLC_ADDR_AUX_CTRL, 8'h00);
      c2 <= 1'b1;
      run <= 1'b1;
      wt(6);
      `CHK(tmr_gate, 1'b1)
      ticks();
      `CHK(n >= 15 && n <= 28, 1'b1)
      c2 <= 1'b0;
      wt(6);
      ticks();
      `CHK(n, 0)
      tmr_gate_en <= 1'b0;
      wt(1);
      ticks();
      `CHK(n >= 15 && n <= 28, 1'b1)
      tmr_on <= 1'b0;
      wt(1);
      ticks();
      `CHK(n, 0)
      tmr_on <= 1'b1;
      tmr_gate_en <= 1'b1;
      wr(CMPLC_ADDR_AUX_CTRL, 8'h01);
      run <= 1'b0;
      wt(20);
      c2 <= 1'b1;
      wt(10);
      `CHK(tmr_gate, 1'b0)
      run <= 1'b1;
      wt(25);
      `CHK(tmr_gate, 1'b1)
      wr(CMPLC_ADDR_AUX_CTRL, 8'h03);
      g <= 1'b0;
      wt(6);
      `CHK(tmr_gate, 1'b0)
      g <= 1'b1;
      c2 <= 1'b0;
      wt(6);
      `CHK(tmr_gate, 1'b1)
      run <= 1'b0;
   endtask
   task automatic t_ladder();
      wr(CMPLC_ADDR_LADDER_CTRL, 8'h20);
      wt(1);
      `CHK({ladder.clamp_gnd, ladder.power}, 2'b10)
      wr(CMPLC_ADDR_LADDER_CTRL, 8'hbf);
      wt(1);
      `CHK({ladder.power, ladder.range_low, ladder.level, ladder.clamp_gnd}, 7'h7e)
      `CHK({ladder.pin_out, ladder.source_ext}, 2'b01)
      wr(CMPLC_ADDR_LADDER_CTRL, 8'hc5);
      wt(1);
      `CHK({ladder.power, ladder.pin_out, ladder.range_low, ladder.source_ext, ladder.level}, 8'hc5)
      rchk(CMPLC_ADDR_LADDER_CTRL, 8'hc5);
      wr(CMPLC_ADDR_LADDER_CTRL, 8'h00);
      wt(1);
      `CHK(ladder.clamp_gnd, 1'b0)
   endtask
   task automatic t_fixed();
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h01);
      wt(2);
      `CHK(fixed, 1'b1)
      wr(CMPLC_ADDR_LATCH_CTRL, 8'h00);
      wt(2);
      `CHK(fixed, 1'b0)
      osc <= 1'b1;
      wt(6);
      `CHK(fixed, 1'b1)
      osc <= 1'b0;
   endtask
   task automatic t_mid_reset();
      wr(CMPLC_ADDR_LATCH_CTRL, 8'hc8);
      wr(CMPLC_ADDR_AUX_CTRL, 8'h31);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wt(1);
      t_reset();
   endtask

   // ==========================
   // verdict
   task automatic finish_test();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================
   // main sequence
   initial begin
      rst_b = 1'b0;
      bus = '0;
      {tmr_on, tmr_gate_en, c1, c2, run, g, osc} = 7'h00;
      dir = 2'b11;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      wt(1);
      t_reset();
      t_mirror();
      t_refsel();
      t_latch();
      t_pins();
      t_timer();
      t_ladder();
      t_fixed();
      t_mid_reset();
      finish_test();
   end
endmodule
